// >>> logic/indication_pkg.sv
// Constants and types for alarm, error code and tare indication
// What this block does
// R1 - Min/max alarm function: min alarm lights alarm+min, max alarm lights alarm+max.
// R2 - System alarm or error lights min, max and alarm, and shows its code; here only system_alarm, self_fail and sensor_fail light them.
// R3 - Code 1 while input above measuring range; clears when back in range.
// R4 - Code 2 while input below measuring range; clears when back in range.
// R5 - Code 3 while display value above 9999; clears below 9999.
// R6 - Code 4 while display value below -1999; clears above -1999.
// R7 - Self-diagnostic failure shows code 7.
// R8 - Sensor broken or shorted shows code 9.
// R9 - Faulty intermediate value shows code 11 instead of a reading.
// R10 - Configuration that cannot give a valid value shows code 12.
// R11 - Short tare press stores current value; display becomes relative, starting at 0.
// R12 - Holding tare about two seconds clears tare; absolute value shown again.
// R13 - Tare LED flashes while a tare is active.
// R14 - No tare at value 0; press at displayed 0 with tare active clears it.
// R15 - Serial link is slave only; answers only host requests.
// R16 - Holds a unique ID and accepts a host-assigned bus address.
// R17 - Several errors: one code by fixed priority, system and sensor first.
package indication_pkg;
   localparam int          VAL_W          = 16;
   localparam logic [15:0] DISP_MAX       = 16'h270F;  // 9999
   localparam logic [15:0] DISP_MIN       = 16'hF831;  // -1999
   localparam logic [3:0]  ERR_NONE       = 4'h0;
   localparam logic [3:0]  ERR_RANGE_HI   = 4'h1;
   localparam logic [3:0]  ERR_RANGE_LO   = 4'h2;
   localparam logic [3:0]  ERR_DISP_HI    = 4'h3;
   localparam logic [3:0]  ERR_DISP_LO    = 4'h4;
   localparam logic [3:0]  ERR_SYSTEM     = 4'h7;
   localparam logic [3:0]  ERR_SENSOR     = 4'h9;
   localparam logic [3:0]  ERR_CALC       = 4'hB;
   localparam logic [3:0]  ERR_CONFIG     = 4'hC;
   localparam int          CLK_HZ         = 250000000;
   localparam int          HOLD_MS        = 2000;
   localparam int          FLASH_MS       = 250;
   localparam longint      HOLD_CYC_L     = longint'(CLK_HZ) / 1000 * HOLD_MS;
   localparam longint      FLASH_CYC_L    = longint'(CLK_HZ) / 1000 * FLASH_MS;
   localparam logic [31:0] UNIQUE_ID      = 32'h0000A5A5;  // Arbitrary value
   localparam logic [7:0]  ADDR_RESET     = 8'h01;
   localparam logic [7:0]  CMD_READ_VAL   = 8'h01;
   localparam logic [7:0]  CMD_READ_ID    = 8'h02;
   localparam logic [7:0]  CMD_READ_ERR   = 8'h03;
   localparam logic [7:0]  CMD_SET_ADDR   = 8'h04;
   typedef enum logic [1:0]
   {
      KEY_IDLE = 2'b00,
      KEY_HELD = 2'b01,
      KEY_DONE = 2'b10
   } key_state_e;
endpackage

// >>> logic/error_classifier.sv
// Combinational error code selection by fixed priority
`timescale 1ns/1ps
module error_classifier
   import indication_pkg::*;
(
   input  wire logic              range_hi,
   input  wire logic              range_lo,
   input  wire logic              self_fail,
   input  wire logic              sensor_fail,
   input  wire logic              calc_fault,
   input  wire logic              config_bad,
   input  wire logic [VAL_W-1:0]  disp_value,
   output logic      [3:0]        code
);
   always_comb
   begin
      // System and sensor faults mask everything derived from the reading
      if (self_fail)                                   // R17
         code = ERR_SYSTEM;                            // R7
      else if (sensor_fail)
         code = ERR_SENSOR;                            // R8
      else if (config_bad)
         code = ERR_CONFIG;                            // R10
      else if (calc_fault)
         code = ERR_CALC;                              // R9
      else if (range_hi)
         code = ERR_RANGE_HI;                          // R3
      else if (range_lo)
         code = ERR_RANGE_LO;                          // R4
      else if ($signed(disp_value) > $signed(DISP_MAX))
         code = ERR_DISP_HI;                           // R5
      else if ($signed(disp_value) < $signed(DISP_MIN))
         code = ERR_DISP_LO;                           // R6
      else
         code = ERR_NONE;
   end
endmodule

// >>> logic/alarm_error_tare_indication.sv
// Alarm LEDs, error code display, tare function and serial slave
`timescale 1ns/1ps
module alarm_error_tare_indication
   import indication_pkg::*;
#(
   parameter longint HOLD_CYC  = HOLD_CYC_L,
   parameter longint FLASH_CYC = FLASH_CYC_L
)
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              min_max_alarm_output_function,
   input  wire logic              min_alarm,
   input  wire logic              max_alarm,
   input  wire logic              system_alarm,
   input  wire logic              range_hi,
   input  wire logic              range_lo,
   input  wire logic              self_fail,
   input  wire logic              sensor_fail,
   input  wire logic              calc_fault,
   input  wire logic              config_bad,
   input  wire logic [VAL_W-1:0]  meas_value,
   input  wire logic              tare_key,
   input  wire logic              host_req,
   input  wire logic [7:0]        host_cmd,
   input  wire logic [7:0]        host_addr,
   input  wire logic [7:0]        host_arg,
   output logic      [VAL_W-1:0]  disp_value,
   output logic      [3:0]        err_code,
   output logic                   err_show,
   output logic                   led_alarm,
   output logic                   led_min,
   output logic                   led_max,
   output logic                   tare_active_led,
   output logic                   tare_active,
   output logic                   resp_valid,
   output logic      [31:0]       resp_data,
   output logic      [7:0]        bus_addr
);
   // Counters are 32 bits; the two-second hold fits comfortably
   logic [VAL_W-1:0] tare_ref, next_tare_ref, rel_value;
   logic             next_tare_active;
   key_state_e       key_st, next_key_st;
   logic [31:0]      hold_cnt, next_hold_cnt;
   logic [31:0]      flash_cnt, next_flash_cnt;
   logic             flash_ph, next_flash_ph;
   logic [3:0]       code;
   logic             sys_err;
   logic             next_led_alarm, next_led_min, next_led_max;
   logic             next_resp_valid;
   logic [31:0]      next_resp_data;
   logic [7:0]       next_bus_addr;

   assign rel_value = tare_active ? meas_value - tare_ref : meas_value;  // R11

   error_classifier u_class
   (
      .range_hi    (range_hi),
      .range_lo    (range_lo),
      .self_fail   (self_fail),
      .sensor_fail (sensor_fail),
      .calc_fault  (calc_fault),
      .config_bad  (config_bad),
      .disp_value  (rel_value),
      .code        (code)
   );

   assign sys_err = system_alarm | self_fail | sensor_fail;

   // Alarm LEDs
   always_comb
   begin
      next_led_min   = 1'b0;
      next_led_max   = 1'b0;
      if (sys_err)
      begin
         next_led_min = 1'b1;                          // R2
         next_led_max = 1'b1;
      end
      else if (min_max_alarm_output_function)
      begin
         next_led_min = min_alarm;                     // R1
         next_led_max = max_alarm;
      end
      next_led_alarm = next_led_min | next_led_max;
   end

   // Tare key: action decided on release so a long hold never sets a tare
   always_comb
   begin
      next_key_st      = key_st;
      next_hold_cnt    = hold_cnt;
      next_tare_ref    = tare_ref;
      next_tare_active = tare_active;
      unique case (key_st)
         KEY_IDLE:
         begin
            next_hold_cnt = 32'h0;
            if (tare_key)
               next_key_st = KEY_HELD;
         end
         KEY_HELD:
         begin
            if (!tare_key)
            begin
               next_key_st = KEY_IDLE;
               if (tare_active && rel_value == '0)
                  next_tare_active = 1'b0;             // R14
               else if (meas_value != '0)
               begin
                  next_tare_ref    = meas_value;       // R11
                  next_tare_active = 1'b1;
               end
            end
            else if (hold_cnt >= 32'(HOLD_CYC - 1))
            begin
               next_key_st      = KEY_DONE;
               next_tare_active = 1'b0;                // R12
            end
            else
               next_hold_cnt = hold_cnt + 32'h1;
         end
         KEY_DONE:
         begin
            if (!tare_key)
               next_key_st = KEY_IDLE;
         end
         default:
            next_key_st = KEY_IDLE;
      endcase
   end

   // Tare LED blink
   always_comb
   begin
      next_flash_cnt = 32'h0;
      next_flash_ph  = 1'b0;
      if (tare_active)
      begin
         next_flash_ph = flash_ph;
         if (flash_cnt >= 32'(FLASH_CYC - 1))
            next_flash_ph = ~flash_ph;                 // R13
         else
            next_flash_cnt = flash_cnt + 32'h1;
      end
   end

   // Serial slave: speaks only when addressed by the host
   always_comb
   begin
      next_resp_valid = 1'b0;
      next_resp_data  = resp_data;
      next_bus_addr   = bus_addr;
      if (host_req && host_addr == bus_addr)           // R15
      begin
         next_resp_valid = 1'b1;
         unique case (host_cmd)
            CMD_READ_VAL: next_resp_data = {{(32-VAL_W){rel_value[VAL_W-1]}}, rel_value};
            CMD_READ_ID:  next_resp_data = UNIQUE_ID;  // R16
            CMD_READ_ERR: next_resp_data = {28'h0, code};
            CMD_SET_ADDR:
            begin
               next_bus_addr  = host_arg;              // R16
               next_resp_data = {24'h0, host_arg};
            end
            default:      next_resp_valid = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         key_st          <= KEY_IDLE;
         hold_cnt        <= 32'h0;
         tare_ref        <= '0;
         tare_active     <= 1'b0;
         flash_cnt       <= 32'h0;
         flash_ph        <= 1'b0;
         tare_active_led <= 1'b0;
         led_alarm       <= 1'b0;
         led_min         <= 1'b0;
         led_max         <= 1'b0;
         disp_value      <= '0;
         err_code        <= ERR_NONE;
         err_show        <= 1'b0;
         resp_valid      <= 1'b0;
         resp_data       <= 32'h0;
         bus_addr        <= ADDR_RESET;
      end
      else
      begin
         key_st          <= next_key_st;
         hold_cnt        <= next_hold_cnt;
         tare_ref        <= next_tare_ref;
         tare_active     <= next_tare_active;
         flash_cnt       <= next_flash_cnt;
         flash_ph        <= next_flash_ph;
         tare_active_led <= next_flash_ph;
         led_alarm       <= next_led_alarm;
         led_min         <= next_led_min;
         led_max         <= next_led_max;
         disp_value      <= rel_value;
         err_code        <= code;                      // R17
         err_show        <= (code != ERR_NONE);        // R3
         resp_valid      <= next_resp_valid;
         resp_data       <= next_resp_data;
         bus_addr        <= next_bus_addr;
      end
   end

   property p_sys_leds;
      @(posedge clk) disable iff (!resetn)
      sys_err |=> (led_min && led_max && led_alarm);
   endproperty
   a_sys_leds: assert property (p_sys_leds) else $error("system fault did not light all alarm LEDs"); // R2

   property p_min_led;
      @(posedge clk) disable iff (!resetn)
      (!sys_err && min_max_alarm_output_function && min_alarm && !max_alarm) |=> (led_min && led_alarm && !led_max);
   endproperty
   a_min_led: assert property (p_min_led) else $error("min alarm LEDs wrong"); // R1

   property p_no_func;
      @(posedge clk) disable iff (!resetn)
      (!sys_err && !min_max_alarm_output_function) |=> !led_alarm;
   endproperty
   a_no_func: assert property (p_no_func) else $error("alarm LED lit without function"); // R1

   property p_sys_code;
      @(posedge clk) disable iff (!resetn)
      self_fail |=> (err_code == ERR_SYSTEM && err_show);
   endproperty
   a_sys_code: assert property (p_sys_code) else $error("self failure not shown as code 7"); // R7

   property p_sensor_code;
      @(posedge clk) disable iff (!resetn)
      (sensor_fail && !self_fail) |=> err_code == ERR_SENSOR;
   endproperty
   a_sensor_code: assert property (p_sensor_code) else $error("sensor failure not shown as code 9"); // R8

   property p_range_hi;
      @(posedge clk) disable iff (!resetn)
      (range_hi && !self_fail && !sensor_fail && !config_bad && !calc_fault) |=> err_code == ERR_RANGE_HI;
   endproperty
   a_range_hi: assert property (p_range_hi) else $error("over range not shown as code 1"); // R3

   property p_range_lo;
      @(posedge clk) disable iff (!resetn)
      (range_lo && !range_hi && !self_fail && !sensor_fail && !config_bad && !calc_fault)
         |=> err_code == ERR_RANGE_LO;
   endproperty
   a_range_lo: assert property (p_range_lo) else $error("under range not shown as code 2"); // R4

   property p_disp_hi;
      @(posedge clk) disable iff (!resetn)
      (!range_hi && !range_lo && !self_fail && !sensor_fail && !config_bad && !calc_fault
         && $signed(rel_value) > $signed(DISP_MAX)) |=> err_code == ERR_DISP_HI;
   endproperty
   a_disp_hi: assert property (p_disp_hi) else $error("display overflow not shown as code 3"); // R5

   property p_disp_lo;
      @(posedge clk) disable iff (!resetn)
      (!range_hi && !range_lo && !self_fail && !sensor_fail && !config_bad && !calc_fault
         && $signed(rel_value) < $signed(DISP_MIN)) |=> err_code == ERR_DISP_LO;
   endproperty
   a_disp_lo: assert property (p_disp_lo) else $error("display underflow not shown as code 4"); // R6

   property p_calc_code;
      @(posedge clk) disable iff (!resetn)
      (calc_fault && !config_bad && !self_fail && !sensor_fail) |=> err_code == ERR_CALC;
   endproperty
   a_calc_code: assert property (p_calc_code) else $error("faulty intermediate not shown as code 11"); // R9

   property p_config_code;
      @(posedge clk) disable iff (!resetn)
      (config_bad && !self_fail && !sensor_fail) |=> err_code == ERR_CONFIG;
   endproperty
   a_config_code: assert property (p_config_code) else $error("bad configuration not shown as code 12"); // R10

   property p_long_hold;
      @(posedge clk) disable iff (!resetn)
      (key_st == KEY_HELD && tare_key && hold_cnt >= 32'(HOLD_CYC - 1)) |=> !tare_active;
   endproperty
   a_long_hold: assert property (p_long_hold) else $error("long key hold did not clear tare"); // R12

   property p_set_addr;
      @(posedge clk) disable iff (!resetn)
      (host_req && host_addr == bus_addr && host_cmd == CMD_SET_ADDR) |=> (resp_valid && bus_addr == $past(host_arg));
   endproperty
   a_set_addr: assert property (p_set_addr) else $error("host address not taken"); // R16

   property p_tare_zero;
      @(posedge clk) disable iff (!resetn)
      (key_st == KEY_HELD && !tare_key && !tare_active && meas_value == '0) |=> !tare_active;
   endproperty
   a_tare_zero: assert property (p_tare_zero) else $error("tare set at value zero"); // R14

   property p_tare_set;
      @(posedge clk) disable iff (!resetn)
      (key_st == KEY_HELD && !tare_key && !tare_active && meas_value != '0) ##1 (meas_value == $past(meas_value))
         |=> disp_value == '0;
   endproperty
   a_tare_set: assert property (p_tare_set) else $error("display not zero after tare"); // R11

   property p_led_off;
      @(posedge clk) disable iff (!resetn)
      !tare_active ##1 !tare_active |=> !tare_active_led;
   endproperty
   a_led_off: assert property (p_led_off) else $error("tare LED lit without tare"); // R13

   property p_slave;
      @(posedge clk) disable iff (!resetn)
      !(host_req && host_addr == bus_addr) |=> !resp_valid;
   endproperty
   a_slave: assert property (p_slave) else $error("answer without request"); // R15

   c_tare: cover property (@(posedge clk) disable iff (!resetn) $rose(tare_active));
   c_clear: cover property (@(posedge clk) disable iff (!resetn) $fell(tare_active));
   c_sys: cover property (@(posedge clk) disable iff (!resetn) sys_err ##1 led_alarm);
   c_resp: cover property (@(posedge clk) disable iff (!resetn) resp_valid);
endmodule

// >>> test/front_end_model.sv
// Behavioural front end and tare key feeding the indication block
`timescale 1ns/1ps
module front_end_model
   import indication_pkg::*;
(
   output logic             min_max_alarm_output_function,
   output logic             min_alarm,
   output logic             max_alarm,
   output logic             system_alarm,
   output logic             range_hi,
   output logic             range_lo,
   output logic             self_fail,
   output logic             sensor_fail,
   output logic             calc_fault,
   output logic             config_bad,
   output logic [VAL_W-1:0] meas_value,
   output logic             tare_key
);
   // Bits: 0 self, 1 sensor, 2 config, 3 calc, 4 hi, 5 lo, 6 min, 7 max, 8 sys, 9 fn
   task automatic drive(input logic [9:0] f, input logic [VAL_W-1:0] v);
      {min_max_alarm_output_function, system_alarm, max_alarm, min_alarm} = f[9:6];
      {range_lo, range_hi, calc_fault, config_bad, sensor_fail, self_fail} = f[5:0];
      meas_value = v;
   endtask
   task automatic key(input logic k);
      tare_key = k;
   endtask
   initial
   begin
      drive(10'h000, 16'h0000);
      key(1'b0);
   end
endmodule

// >>> test/test_alarm_error_tare_indication.sv
// Self-checking bench for alarm, error code, tare and serial slave
`timescale 1ns/1ps
module test_alarm_error_tare_indication
   import indication_pkg::*;
;
   logic clk, resetn, host_req;
   logic [7:0] host_cmd, host_addr, host_arg;
   logic fn, mn, mx, sy, rh, rl, sf, sn, cf, cb, tk;
   logic [VAL_W-1:0] mv, disp_value;
   logic [3:0] err_code;
   logic err_show, led_alarm, led_min, led_max, tare_active_led, tare_active, resp_valid;
   logic [31:0] resp_data;
   logic [7:0] bus_addr;
   logic [31:0] seed = 32'h0ABA1E98;
   int err_count = 0, n_compared = 0;
   front_end_model u_fe (.min_max_alarm_output_function(fn), .min_alarm(mn), .max_alarm(mx),
      .system_alarm(sy), .range_hi(rh), .range_lo(rl), .self_fail(sf), .sensor_fail(sn),
      .calc_fault(cf), .config_bad(cb), .meas_value(mv), .tare_key(tk));
   alarm_error_tare_indication #(.HOLD_CYC(20), .FLASH_CYC(4)) u_dut (.clk(clk), .resetn(resetn),
      .min_max_alarm_output_function(fn), .min_alarm(mn), .max_alarm(mx), .system_alarm(sy),
      .range_hi(rh), .range_lo(rl), .self_fail(sf), .sensor_fail(sn), .calc_fault(cf),
      .config_bad(cb), .meas_value(mv), .tare_key(tk), .host_req(host_req), .host_cmd(host_cmd),
      .host_addr(host_addr), .host_arg(host_arg), .disp_value(disp_value), .err_code(err_code),
      .err_show(err_show), .led_alarm(led_alarm), .led_min(led_min), .led_max(led_max),
      .tare_active_led(tare_active_led), .tare_active(tare_active), .resp_valid(resp_valid),
      .resp_data(resp_data), .bus_addr(bus_addr));
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [3:0] exp_code(logic [9:0] f, logic [15:0] v);
      if (f[0]) return ERR_SYSTEM;
      if (f[1]) return ERR_SENSOR;
      if (f[2]) return ERR_CONFIG;
      if (f[3]) return ERR_CALC;
      if (f[4]) return ERR_RANGE_HI;
      if (f[5]) return ERR_RANGE_LO;
      if ($signed(v) > 16'sd9999) return ERR_DISP_HI;
      if ($signed(v) < -16'sd1999) return ERR_DISP_LO;
      return ERR_NONE;
   endfunction
   task automatic end_of_test();
      if (err_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk_bit(string what, logic exp, logic got);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_vec(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic press(int n);
      u_fe.key(1'b1);
      cyc(n);
      u_fe.key(1'b0);
      cyc(3);
   endtask
   task automatic host(logic [7:0] a, logic [7:0] c, logic [7:0] g, logic ans, logic [31:0] exp);
      host_req = 1'b1;
      host_addr = a;
      host_cmd = c;
      host_arg = g;
      cyc(1);
      host_req = 1'b0;
      chk_bit("resp_valid", ans, resp_valid);
      if (ans)
         chk_vec("resp_data", exp, resp_data);
      // Idle edge keeps back-to-back calls from re-raising the strobe at once
      cyc(1);
   endtask
   initial
   begin
      #40000;
      err_count++;
      end_of_test();
   end
   initial
   begin
      logic [9:0] f;
      logic [15:0] v;
      logic [3:0] c;
      logic sys;
      int tog;
      resetn = 1'b0;
      host_req = 1'b0;
      host_cmd = 8'h00;
      host_addr = 8'h00;
      host_arg = 8'h00;
      cyc(20);
      resetn = 1'b1;
      chk_vec("bus_addr", ADDR_RESET, bus_addr);
      // Corner values of the display range sit among random ones
      for (int i = 0; i < 400; i++)
      begin
         f = 10'(rnd() & rnd());
         f[9] = 1'(rnd());
         v = (i % 5 == 0) ? 16'h270F : (i % 5 == 1) ? 16'h2710 : (i % 5 == 2) ? 16'hF831 :
             (i % 5 == 3) ? 16'hF830 : 16'(rnd());
         u_fe.drive(f, v);
         cyc(1);
         c = exp_code(f, v);
         chk_vec("err_code", c, err_code);
         chk_bit("err_show", c != ERR_NONE, err_show);
         sys = f[8] | f[1] | f[0];
         chk_bit("led_min", (f[9] & f[6]) | sys, led_min);
         chk_bit("led_max", (f[9] & f[7]) | sys, led_max);
         chk_bit("led_alarm", (f[9] & (f[6] | f[7])) | sys, led_alarm);
         if (c == ERR_NONE)
            chk_vec("disp_value", v, disp_value);
      end
      u_fe.drive(10'h000, 16'h0064);
      press(1);
      chk_bit("tare_active", 1'b1, tare_active);
      chk_vec("disp_value", 16'h0000, disp_value);
      u_fe.drive(10'h000, 16'h0096);
      tog = 0;
      for (int i = 0; i < 20; i++)
      begin
         sys = tare_active_led;
         cyc(1);
         tog += (sys !== tare_active_led);
      end
      chk_vec("disp_value", 16'h0032, disp_value);
      chk_bit("led_flash", 1'b1, tog >= 4 && tog <= 6);
      u_fe.drive(10'h000, 16'h0064);
      cyc(1);
      press(1);
      chk_bit("tare_active", 1'b0, tare_active);
      chk_bit("tare_active_led", 1'b0, tare_active_led);
      chk_vec("disp_value", 16'h0064, disp_value);
      u_fe.drive(10'h000, 16'h0000);
      press(2);
      chk_bit("tare_active", 1'b0, tare_active);
      u_fe.drive(10'h000, 16'h00C8);
      press(1);
      chk_bit("tare_active", 1'b1, tare_active);
      u_fe.key(1'b1);
      cyc(19);
      chk_bit("tare_active", 1'b1, tare_active);
      cyc(6);
      chk_bit("tare_active", 1'b0, tare_active);
      u_fe.key(1'b0);
      cyc(3);
      chk_bit("tare_active", 1'b0, tare_active);
      chk_vec("disp_value", 16'h00C8, disp_value);
      u_fe.drive(10'h001, 16'hFF38);
      cyc(1);
      host(8'h01, CMD_READ_ID, 8'h00, 1'b1, UNIQUE_ID);
      host(8'h01, CMD_READ_ERR, 8'h00, 1'b1, {28'h0, ERR_SYSTEM});
      host(8'h01, CMD_READ_VAL, 8'h00, 1'b1, 32'hFFFFFF38);
      host(8'h01, 8'h7E, 8'h00, 1'b0, 32'h0);
      host(8'h01, CMD_SET_ADDR, 8'h22, 1'b1, 32'h00000022);
      chk_vec("bus_addr", 32'h22, bus_addr);
      host(8'h01, CMD_READ_ID, 8'h00, 1'b0, 32'h0);
      host(8'h22, CMD_READ_ID, 8'h00, 1'b1, UNIQUE_ID);
      end_of_test();
   end
endmodule
